// [entry_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module entry_fifo
    import timed_output_pkg::*;
#(
    parameter int W     = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // Fill side
    input  wire logic                 push,
    input  wire logic [W-1:0]         push_data,
    // Drain side
    input  wire logic                 pop,
    output logic [W-1:0]              head,
    // State
    output logic [$clog2(DEPTH):0]    level,
    output logic                      empty,
    output logic                      full
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   level_ff;
    logic          do_push;
    logic          do_pop;

    assign do_push = push && (level_ff != (AW+1)'(DEPTH));
    assign do_pop  = pop && (level_ff != '0);

    // Storage kept in written order
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_ff[wr_ff] <= push_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            level_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            level_ff <= level_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // Vacated slots present as zero at the head
    assign head  = (level_ff == '0) ? '0 : mem_ff[rd_ff];
    assign level = level_ff;
    assign empty = (level_ff == '0);
    assign full  = (level_ff == (AW+1)'(DEPTH));

endmodule : entry_fifo
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model
    import timed_output_pkg::*;
(
    // Clock
    input wire logic         ref_clk,
    // Bus
    input wire logic [31:0]  readdata,
    input wire logic         waitrequest,
    output var logic [7:0]   address,
    output var logic         read,
    output var logic         write,
    output var logic [31:0]  writedata,
    output var logic [3:0]   byteenable
);
    initial begin
        address    = 8'h00;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0000_0000;
        byteenable = 4'hF;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output bit ok);
        int n;
        ok = 0;
        q  = 32'h0000_0000;
        @(posedge ref_clk);
        address   <= a;
        writedata <= d;
        read      <= !w;
        write     <= w;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) begin
                q  = readdata;
                ok = 1;
            end
        end
        read  <= 1'b0;
        write <= 1'b0;
    endtask : xfer

    // One bus word carries one whole entry
    task automatic put_entry(input logic [7:0] slot, input logic [7:0] pat,
                             input logic [7:0] rn, input logic [15:0] t,
                             output bit ok);
        timed_output_entry_s e;
        logic [31:0]         q;
        e.entry_time_us    = t;
        e.entry_ref_number = rn;
        e.pattern          = pat;
        xfer(1'b1, slot, e, q, ok);
    endtask : put_entry
endmodule : host_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import timed_output_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [3:0]  output_channel;
    logic        irq;
    int          num_errors = 0;
    int          tests_run  = 0;
    logic [7:0]  pat [5] = '{8'h30, 8'hB0, 8'hF0, 8'h30, 8'h70};

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    timed_output_scheduler #(.TICK_DIV(4)) timed_output_scheduler_inst (
        .ref_clk(ref_clk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .output_channel(output_channel), .irq(irq)
    );

    host_model host_model_inst (
        .ref_clk(ref_clk), .readdata(readdata), .waitrequest(waitrequest),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q);
        bit ok;
        host_model_inst.xfer(w, a, d, q, ok);
        if (!ok) begin
            num_errors++;
            report_and_stop();
        end
    endtask : bus

    task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, q, e);
    endtask : rd_chk

    task automatic put(logic [7:0] s, logic [7:0] p, logic [7:0] r,
                       logic [15:0] t);
        bit ok;
        host_model_inst.put_entry(s, p, r, t, ok);
        if (!ok) begin
            num_errors++;
            report_and_stop();
        end
    endtask : put

    function automatic logic [3:0] chan(logic [7:0] p);
        return {p[4], p[5], p[6], p[7]};
    endfunction : chan

    task automatic t_reset_state();
        rd_chk("status", 8'h20, 32'h0001_C000);
        rd_chk("image", 8'h00, 32'h0000_0000);
        rd_chk("unmapped", 8'h30, 32'h0000_0000);
        rd_chk("irq_status", 8'h28, 32'h0000_0000);
        rd_chk("irq_mask", 8'h2C, 32'h0000_0000);
        chk("outputs", 32'(output_channel), 32'h0);
        $display("test reset_state done");
    endtask : t_reset_state

    task automatic t_five_entries();
        logic [31:0] q;
        logic [15:0] t0;
        int          i;
        int          n;
        bus(1'b1, 8'h2C, 32'h1, q);
        bus(1'b0, 8'h24, 32'h0, q);
        t0 = q[15:0];
        for (i = 0; i < 5; i++)
            put(8'(4 * i), pat[i], 8'(i + 1), t0 + 16'(50 + 10 * i));
        rd_chk("status", 8'h20, 32'h0500_C100);
        for (i = 0; i < 5; i++) begin
            for (n = 0; n < 4000 && irq !== 1'b1; n++)
                @(posedge ref_clk);
            if (n == 4000) begin
                num_errors++;
                report_and_stop();
            end
            chk("outputs", 32'(output_channel), 32'(chan(pat[i])));
            rd_chk("irq_status", 8'h28, (i == 4) ? 32'h5 : 32'h1);
            rd_chk("status", 8'h20, {8'(4 - i), (i == 4) ? 8'h01 : 8'h00,
                (i == 4) ? 8'hC0 : 8'(8'hC2 + i), 8'(i + 1)});
        end
        $display("test five_entries done");
    endtask : t_five_entries

    task automatic t_wrap_and_full();
        logic [31:0] q;
        logic [15:0] t0;
        int          k;
        bus(1'b1, 8'h2C, 32'h2, q);
        bus(1'b0, 8'h24, 32'h0, q);
        t0 = q[15:0] - 16'd2;
        put(8'h00, 8'hA0, 8'h21, t0);
        repeat (400) @(posedge ref_clk);
        chk("outputs", 32'(output_channel), 32'(chan(8'h70)));
        rd_chk("status", 8'h20, 32'h0100_E105);
        for (k = 1; k < 33; k++)
            put(8'h04, 8'h50, 8'(k), t0);
        @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h1);
        rd_chk("status", 8'h20, 32'h2006_E105);
        rd_chk("status", 8'h20, 32'h2002_E105);
        bus(1'b1, 8'h2C, 32'h0, q);
        @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h0);
        bus(1'b1, 8'h2C, 32'h2, q);
        @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h1);
        rd_chk("irq_status", 8'h28, 32'h2);
        @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h0);
        $display("test wrap_and_full done");
    endtask : t_wrap_and_full

    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset_state();
        t_five_entries();
        t_wrap_and_full();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// [timed_output_pkg.sv]
package timed_output_pkg;

    // ------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ   = 250;
    localparam int TICK_PERIOD_US = 1;
    localparam int TICK_CYCLES    = CLK_FREQ_MHZ * TICK_PERIOD_US;
    localparam int TICKER_W       = 16;

    // ------------------------------------------------------------
    // Output image geometry
    // ------------------------------------------------------------
    localparam int IMAGE_ENTRIES  = 5;
    localparam int ENTRY_BYTES    = 4;
    localparam int FIFO_DEPTH     = 32;
    localparam int NUM_CHANNELS   = 4;
    localparam int PATTERN_MSB    = 7;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IMAGE_FIRST = 8'h00;
    localparam logic [7:0] OFS_IMAGE_LAST  = 8'h10;
    localparam logic [7:0] OFS_STATUS      = 8'h20;
    localparam logic [7:0] OFS_TICKER      = 8'h24;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h2C;

    // ------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LAST_REF_RST    = 8'h00;
    localparam logic [1:0] NEXT_REF_TOP    = 2'b11;
    localparam int         NEXT_REF_LOW_W  = 6;
    localparam int         QS_EMPTY_BIT    = 0;
    localparam int         QS_FULL_BIT     = 1;
    localparam int         QS_OVF_BIT      = 2;

    // Interrupt bits
    localparam int         IRQ_W           = 3;
    localparam int         IRQ_FIRED_BIT   = 0;
    localparam int         IRQ_OVF_BIT     = 1;
    localparam int         IRQ_EMPTY_BIT   = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // Scheduled entry
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] entry_time_us;
        logic [7:0]  entry_ref_number;
        logic [7:0]  pattern;
    } timed_output_entry_s;

    localparam int ENTRY_W = $bits(timed_output_entry_s);

endpackage : timed_output_pkg

// [timed_output_scheduler.sv]
// Behaviour
// - Written image entries go straight into the queue in written order.
// - The image holds five four-byte entries: pattern, reference, time.
// - Channel 0 takes pattern bit 7 down to channel 3 from bit 4.
// - At its time an entry's pattern drives the outputs until the next one.
// - Entries run one at a time from the queue head and leave once issued.
// - Status reports last and next reference, queue state and count.
// - Next reference carries the low six bits of the queue head entry's number with top two bits set.
`timescale 1ns/1ps
`default_nettype none
module timed_output_scheduler
    import timed_output_pkg::*;
#(
    parameter int DEPTH       = FIFO_DEPTH,
    parameter int TICK_DIV    = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              srst,
    // Avalon-MM slave
    input  wire logic [7:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    // Outputs
    output logic [NUM_CHANNELS-1:0] output_channel,
    // Interrupt
    output logic                   irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int LW = $clog2(DEPTH) + 1;

    // Bus side
    logic                     ack_ff;
    logic [31:0]              readdata_ff;
    logic [31:0]              nxt_readdata;
    logic                     wr_take;
    logic                     rd_take;
    logic                     sel_image;
    logic [31:0]              lane_data;
    logic                     push_req;
    logic                     push_drop;
    logic                     status_rd;
    logic                     irq_status_rd;
    logic                     mask_wr;

    // Ticker and queue
    logic [TICKER_W-1:0]      us_count;
    logic                     us_new;

    timed_output_entry_s      push_entry;
    timed_output_entry_s      head_entry;
    logic [ENTRY_W-1:0]       head_raw;
    logic [LW-1:0]            fifo_level;
    logic                     fifo_empty;
    logic                     fifo_full;
    logic                     fire;
    logic                     head_due;
    logic [NUM_CHANNELS-1:0]  head_channels;

    // Status
    logic [NUM_CHANNELS-1:0]  output_channel_ff;
    logic [7:0]               last_ref_status_ff;
    logic                     overflow_ff;
    logic [7:0]               next_ref_status;
    logic [7:0]               queue_state_byte;
    logic [7:0]               pending_entry_count;
    logic [31:0]              input_process_image;

    // Interrupts
    logic [IRQ_W-1:0]         irq_status_ff;
    logic [IRQ_W-1:0]         irq_mask_ff;
    logic [IRQ_W-1:0]         irq_events;
    logic [IRQ_W-1:0]         irq_reported;
    logic                     empty_d_ff;
    logic                     drained;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait state: data is fetched at the first edge, the master
    // samples waitrequest low at the second, and side effects happen
    // only there so a held request never acts twice.
    assign waitrequest = (read || write) && !ack_ff;
    assign wr_take     = write && ack_ff;
    assign rd_take     = read && ack_ff && !write;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (read || write) && !ack_ff;
        end
    end

    // Five word slots; address bits [1:0] are ignored
    assign sel_image = (address[7:2] >= OFS_IMAGE_FIRST[7:2])
                    && (address[7:2] <= OFS_IMAGE_LAST[7:2]);

    // Unwritten byte lanes enter the entry as zero
    always_comb begin
        lane_data = '0;
        for (int b = 0; b < ENTRY_BYTES; b++) begin
            if (byteenable[b]) begin
                lane_data[b*8 +: 8] = writedata[b*8 +: 8];
            end
        end
    end

    assign push_entry = timed_output_entry_s'(lane_data);

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // Strobes are live only in the answering cycle, so a request held
    // through its wait state acts exactly once.
    assign push_req      = wr_take && sel_image;
    assign push_drop     = push_req && fifo_full;
    assign status_rd     = rd_take && (address[7:2] == OFS_STATUS[7:2]);
    assign irq_status_rd = rd_take && (address[7:2] == OFS_IRQ_STATUS[7:2]);
    assign mask_wr       = wr_take && (address[7:2] == OFS_IRQ_MASK[7:2])
                        && byteenable[0];

    // ------------------------------------------------------------
    // Ticker and queue
    // ------------------------------------------------------------
    // A slower tick only stretches the microsecond; the wrap scales too
    us_ticker #(
        .DIV       (TICK_DIV),
        .W         (TICKER_W)
    ) u_ticker (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .count     (us_count),
        .new_value (us_new)
    );

    entry_fifo #(
        .W         (ENTRY_W),
        .DEPTH     (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .push      (push_req),
        .push_data (push_entry),
        .pop       (fire),
        .head      (head_raw),
        .level     (fifo_level),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    assign head_entry = timed_output_entry_s'(head_raw);

    // Compare only on the cycle the ticker moves, so one entry fires
    // per microsecond and an entry already behind the count waits for
    // the wrap instead of firing at once.
    assign head_due = !fifo_empty
                   && (us_count == head_entry.entry_time_us);
    assign fire     = us_new && head_due;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Channel 0 sits in the top pattern bit, so the nibble is reversed
    always_comb begin
        head_channels = '0;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            head_channels[c] = head_entry.pattern[PATTERN_MSB-c];
        end
    end

    // Channels hold between entries; reset drives them all low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            output_channel_ff <= '0;
        end else if (fire) begin
            output_channel_ff <= head_channels;
        end
    end

    assign output_channel = output_channel_ff;

    // ------------------------------------------------------------
    // Input image status
    // ------------------------------------------------------------
    // Last reference keeps its value when the queue runs dry
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_ref_status_ff <= LAST_REF_RST;
        end else if (fire) begin
            last_ref_status_ff <= head_entry.entry_ref_number;
        end
    end

    // Overflow stays until the status word is read
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            overflow_ff <= 1'b0;
        end else if (push_drop) begin
            overflow_ff <= 1'b1;
        end else if (status_rd) begin
            overflow_ff <= 1'b0;
        end
    end

    // Two flag bits leave room for six reference bits; higher ones alias
    assign next_ref_status = {NEXT_REF_TOP,
        head_entry.entry_ref_number[NEXT_REF_LOW_W-1:0]};

    // Overflow marks a dropped entry, not a late one
    always_comb begin
        queue_state_byte               = '0;
        queue_state_byte[QS_EMPTY_BIT] = fifo_empty;
        queue_state_byte[QS_FULL_BIT]  = fifo_full;
        queue_state_byte[QS_OVF_BIT]   = overflow_ff;
    end

    assign pending_entry_count = 8'(fifo_level);
    // Low to high: last reference, next reference, queue state, count
    assign input_process_image = {pending_entry_count, queue_state_byte,
                                  next_ref_status, last_ref_status_ff};

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Starts as empty so reset itself raises no drained event
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            empty_d_ff <= 1'b1;
        end else begin
            empty_d_ff <= fifo_empty;
        end
    end

    assign drained = fifo_empty && !empty_d_ff;

    always_comb begin
        irq_events                = '0;
        irq_events[IRQ_FIRED_BIT] = fire;
        irq_events[IRQ_OVF_BIT]   = push_drop;
        irq_events[IRQ_EMPTY_BIT] = drained;
    end

    // A read clears only the bits it fetched: an event landing on the
    // fetch edge is missing from the data and must outlive the clear.
    assign irq_reported = irq_status_rd ? readdata_ff[IRQ_W-1:0] : '0;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_reported) | irq_events;
        end
    end

    // A new mask acts from the next cycle; pending bits are kept
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_mask_ff <= IRQ_MASK_RST;
        end else if (mask_wr) begin
            irq_mask_ff <= writedata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        nxt_readdata = '0;
        case (address[7:2])
            OFS_STATUS[7:2]:     nxt_readdata = input_process_image;
            OFS_TICKER[7:2]:     nxt_readdata[TICKER_W-1:0] = us_count;
            OFS_IRQ_STATUS[7:2]: nxt_readdata[IRQ_W-1:0] = irq_status_ff;
            OFS_IRQ_MASK[7:2]:   nxt_readdata[IRQ_W-1:0] = irq_mask_ff;
            default:             nxt_readdata = '0;
        endcase
    end

    // Fetched in the wait state and held until the next read, so the
    // value stands through the answer cycle and after it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            readdata_ff <= '0;
        end else if (read && !ack_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    assign readdata = readdata_ff;

endmodule : timed_output_scheduler
`default_nettype wire

// [timed_output_scheduler_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module sched_checker
    import timed_output_pkg::*;
#(
    parameter int DEPTH    = FIFO_DEPTH,
    parameter int TICK_DIV = TICK_CYCLES
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Outputs
    input wire logic [3:0]  output_channel,
    input wire logic        irq
);
    logic        rd_done;
    logic        st_rd;
    logic [3:0]  prev_out_ff;
    logic [15:0] since_chg_ff;

    assign rd_done = read && !waitrequest;
    assign st_rd   = rd_done && (address[7:2] == 6'h08);

    always_ff @(posedge ref_clk) begin
        prev_out_ff <= output_channel;
    end

    // Saturates so a long idle spell never wraps into a false short gap
    always_ff @(posedge ref_clk) begin
        if (srst)
            since_chg_ff <= 16'hFFFF;
        else if (output_channel != prev_out_ff)
            since_chg_ff <= 16'h0000;
        else if (since_chg_ff != 16'hFFFF)
            since_chg_ff <= since_chg_ff + 16'h0001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_ws_first; $rose(read || write) |-> waitrequest; endproperty
    a_ws_first: assert property (p_ws_first) else $error("no wait state");
    property p_ws_ans; $rose(read || write) |=> !waitrequest; endproperty
    a_ws_ans: assert property (p_ws_ans) else $error("late answer");
    property p_idle; !(read || write) |-> !waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("wait while idle");
    property p_out_rate;
        output_channel != prev_out_ff |-> 32'(since_chg_ff) >= TICK_DIV - 1;
    endproperty
    a_out_rate: assert property (p_out_rate) else $error("fires too fast");
    property p_reset_out;
        $fell(srst) |-> output_channel == 4'h0 && !irq && readdata == 32'h0;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset state");
    property p_img_rd0; rd_done && address < 8'h14 |-> readdata == 32'h0;
    endproperty
    a_img_rd0: assert property (p_img_rd0) else $error("image readable");
    property p_next_top; st_rd |-> readdata[15:14] == 2'b11; endproperty
    a_next_top: assert property (p_next_top) else $error("next top");
    property p_empty_cnt;
        st_rd |-> readdata[16] == (readdata[31:24] == 8'h00);
    endproperty
    a_empty_cnt: assert property (p_empty_cnt) else $error("empty flag");
    property p_full_cnt;
        st_rd |-> readdata[17] == (readdata[31:24] == 8'(DEPTH));
    endproperty
    a_full_cnt: assert property (p_full_cnt) else $error("full flag");
    property p_next_empty;
        st_rd && readdata[31:24] == 8'h00 |-> readdata[15:8] == 8'hC0;
    endproperty
    a_next_empty: assert property (p_next_empty) else $error("next idle");
    property p_rd_stand; $changed(readdata) |-> rd_done; endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("readdata moved");

    c_full: cover property (st_rd && readdata[17]);
    c_fire: cover property (output_channel != prev_out_ff);
    c_irq: cover property ($rose(irq));
endmodule : sched_checker

bind timed_output_scheduler sched_checker #(
    .DEPTH(DEPTH), .TICK_DIV(TICK_DIV)
) sched_checker_inst (
    .ref_clk(ref_clk), .srst(srst), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .output_channel(output_channel), .irq(irq)
);
`default_nettype wire

// [us_ticker.sv]
`timescale 1ns/1ps
`default_nettype none
module us_ticker
    import timed_output_pkg::*;
#(
    parameter int DIV = TICK_CYCLES,
    parameter int W   = TICKER_W
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         srst,
    // Ticker
    output logic [W-1:0]      count,
    output logic              new_value
);

    logic [$clog2(DIV)-1:0] div_ff;
    logic [W-1:0]           count_ff;
    logic                   new_ff;

    // Prescaler: one enable per microsecond
    always_ff @(posedge ref_clk) begin
        if (srst || div_ff == ($clog2(DIV))'(DIV - 1)) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // Free running, wraps to zero at the top
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_ff <= '0;
            new_ff   <= 1'b0;
        end else begin
            new_ff <= (div_ff == ($clog2(DIV))'(DIV - 1));
            if (div_ff == ($clog2(DIV))'(DIV - 1)) begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    assign count     = count_ff;
    assign new_value = new_ff;

endmodule : us_ticker
`default_nettype wire
